/* File: verilog/lic_regs.svh */
/*
 Constants for the local interrupt controller: offsets, field positions,
 reset values. Definitions only; included by bare name.
*/
`ifndef LIC_REGS_SVH
`define LIC_REGS_SVH

// ==========================================================
// Local source indices
`define LIC_SRC_PIN_A 3'h0
`define LIC_SRC_PIN_B 3'h1
`define LIC_SRC_TIMER 3'h2
`define LIC_SRC_PERF 3'h3
`define LIC_SRC_THERM 3'h4
`define LIC_SRC_ERROR 3'h5
`define LIC_NUM_SRC 6

// ==========================================================
// Register word indices inside the 4 KB window (byte address = index * 16)
`define LIC_IDX_ERR_STATUS 8'h28
`define LIC_IDX_CMD_LO 8'h30
`define LIC_IDX_CMD_HI 8'h31
`define LIC_IDX_TIMER 8'h32
`define LIC_IDX_THERM 8'h33
`define LIC_IDX_PERF 8'h34
`define LIC_IDX_PIN_A 8'h35
`define LIC_IDX_PIN_B 8'h36
`define LIC_IDX_ERROR 8'h37
`define LIC_IDX_TIMER_INIT 8'h38
`define LIC_IDX_TIMER_CUR 8'h39
`define LIC_IDX_SPURIOUS 8'h0F

// ==========================================================
// Table entry fields
`define LIC_ENT_VEC_LSB 0
`define LIC_ENT_MODE_LSB 8
`define LIC_ENT_LEVEL_BIT 15
`define LIC_ENT_MASK_BIT 16
`define LIC_ENT_RESET 32'h00010000
`define LIC_NMI_VECTOR 8'h02
`define LIC_ENABLE_BIT 8
`define LIC_ERR_ILLEGAL_REG_BIT 7

// ==========================================================
// Command register fields
`define LIC_CMD_VEC_LSB 0
`define LIC_CMD_MODE_LSB 8
`define LIC_CMD_LEVEL_BIT 15
`define LIC_CMD_SHORT_LSB 18
`define LIC_CMD_DEST_LSB 24

`endif

/* File: verilog/lic_pkg.sv */
/*
 Types for the local interrupt controller.
 Assumes lic_regs.svh supplies the numeric constants.
*/
`default_nettype none
package lic_pkg;
   // Delivery modes for table entries and messages
   typedef enum logic [2:0] {
      LIC_DM_FIXED = 3'h0,
      LIC_DM_SMM = 3'h2,
      LIC_DM_NMI = 3'h4,
      LIC_DM_INIT = 3'h5,
      LIC_DM_START = 3'h6,
      LIC_DM_EXT = 3'h7
   } lic_mode_t;

   // Destination shorthand of an outgoing message
   typedef enum logic [1:0] {
      LIC_SH_NONE = 2'h0,
      LIC_SH_SELF = 2'h1,
      LIC_SH_ALL = 2'h2,
      LIC_SH_OTHERS = 2'h3
   } lic_short_t;

   // One interrupt message, on the link or toward the core
   typedef struct packed {
      logic valid;
      logic [7:0] vector;
      lic_mode_t mode;
      logic level;
      lic_short_t shorthand;
      logic [7:0] dest;
   } lic_msg_t;

   // Register access from the core
   typedef struct packed {
      logic wr;
      logic rd;
      logic [11:0] addr;
      logic [31:0] wdata;
   } lic_req_t;

   typedef enum logic [1:0] {
      LIC_ST_IDLE,
      LIC_ST_SEND,
      LIC_ST_WAIT
   } lic_cmd_state_t;

   // Full state of the controller
   typedef struct packed {
      logic [5:0][31:0] entry;
      logic [5:0] pend;
      logic [5:0] pin_last;
      logic [31:0] cmd_lo;
      logic [31:0] cmd_hi;
      lic_cmd_state_t cmd_state;
      logic [31:0] timer_init;
      logic [31:0] timer_cur;
      logic [7:0] err_status;
      logic [8:0] spurious;
      lic_msg_t link_out;
      lic_msg_t core_out;
      logic [31:0] rdata;
      logic rvalid;
      logic bypass;
   } lic_state_t;
endpackage
`default_nettype wire

/* File: verilog/lic_local_interrupt_controller.sv */
/*
 Local interrupt controller for one processor core.
 Holds the six local source table entries, the two command words, the
 one-shot timer, the error status and the enable word, and drives three
 outputs: the link toward the I/O controller and peer cores, the
 delivery toward its own core, and the legacy bypass line.
 Assumes register accesses come from its own core over a simple
 request port, one cycle per access, always 32 bits wide and aligned;
 that the link partner takes one message per link_ready pulse;
 that incoming link messages are one-cycle valid pulses;
 and that the core accepts one delivery per core_ack.
 All inputs are taken as synchronous to sys_clk; pins driven from
 another clock domain must be synchronised before they reach this block.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lic_regs.svh"

// ==========================================================
// Theory of operation
// Every local source has its own table entry with vector, delivery mode,
// trigger kind and mask. A source event sets a sticky pending bit; the
// lowest pending source index is delivered first, but only when the core
// output is free or is being acknowledged in the same cycle.
// Incoming link messages beat local sources for the core output. There is
// no queue behind the core output: a message that arrives while the core
// has not yet taken the previous one is lost, so the partner must not
// send faster than the core acknowledges.
// An outgoing message is launched by a write to the low command word. A
// write to that word while a message is still in flight is stored but not
// sent; software must see the link go idle before the next command.
// A self or broadcast-to-all message is copied to the core in the cycle
// that the partner accepts it, provided the controller is enabled, the core
// output is free then and no incoming link message arrives in that cycle;
// otherwise only the link copy goes out.
// Register accesses never leave the block. An access to an index that is
// not implemented, or to an address that is not on a 16-byte boundary,
// is refused: the write is dropped, the read returns zero and the error
// status bit is set, raising the error source when it is unmasked.
// While the controller is disabled, local sources other than the error source are not latched and the
// legacy request is passed straight to the core through a flip-flop.
// The timer is one-shot: it fires once as the current count passes from
// one to zero and stays at zero until software writes a new initial count.
// When a fresh event and the delivery clear of the same source fall into
// one cycle, the event wins and the source stays pending.

module lic_local_interrupt_controller (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire lic_pkg::lic_req_t reg_req,
   output logic [31:0] reg_rdata,
   output logic reg_rvalid,
   input wire logic local_irq_pin_a,
   input wire logic local_irq_pin_b,
   input wire logic perf_overflow,
   input wire logic thermal_trip,
   input wire logic legacy_irq,
   input wire lic_pkg::lic_msg_t link_in,
   input wire logic link_ready,
   output lic_pkg::lic_msg_t link_out,
   output lic_pkg::lic_msg_t core_irq,
   input wire logic core_ack,
   output logic core_legacy_irq
);
   lic_pkg::lic_state_t s_q, s_d;
   logic [5:0] src_evt;
   logic [5:0] src_lvl;
   logic [7:0] idx;
   logic enabled;
   logic hit_ok;
   logic timer_fire;
   logic [2:0] pick;
   logic pick_ok;
   // Refused register access and a qualified timer expiry, this cycle
   logic err_hit;
   logic timer_hit;

   // ==========================================================
   // Source conditioning
   assign idx = reg_req.addr[11:4];
   assign enabled = s_q.spurious[`LIC_ENABLE_BIT];
   assign timer_fire = (s_q.timer_cur == 32'h00000001);
   assign src_lvl = {1'b0, thermal_trip, perf_overflow, 1'b0, local_irq_pin_b, local_irq_pin_a};
   // timer_hit is shared by the set and the delivery clear; err_hit repeats the set's condition, so the set can win
   assign err_hit = (reg_req.wr || reg_req.rd) && !hit_ok;
   assign timer_hit = timer_fire && !s_q.entry[`LIC_SRC_TIMER][`LIC_ENT_MASK_BIT] && enabled;

   // Edge or level detection per source; internal sources pulse only
   genvar g;
   generate
      for (g = 0; g < `LIC_NUM_SRC; g++) begin : g_src
         assign src_evt[g] = s_q.entry[g][`LIC_ENT_LEVEL_BIT] ?
            src_lvl[g] : (src_lvl[g] & ~s_q.pin_last[g]);
      end
   endgenerate

   // Valid register indices; all are served here, none reach outside
   always_comb begin
      case (idx)
         `LIC_IDX_ERR_STATUS, `LIC_IDX_CMD_LO, `LIC_IDX_CMD_HI, `LIC_IDX_TIMER,
         `LIC_IDX_THERM, `LIC_IDX_PERF, `LIC_IDX_PIN_A, `LIC_IDX_PIN_B,
         `LIC_IDX_ERROR, `LIC_IDX_TIMER_INIT, `LIC_IDX_TIMER_CUR,
         `LIC_IDX_SPURIOUS: hit_ok = (reg_req.addr[3:0] == 4'h0);
         default: hit_ok = 1'b0;
      endcase
   end

   // Lowest pending source wins delivery
   always_comb begin
      pick = 3'h0;
      pick_ok = 1'b0;
      for (int i = `LIC_NUM_SRC - 1; i >= 0; i--) begin
         if (s_q.pend[i]) begin
            pick = 3'(i);
            pick_ok = 1'b1;
         end
      end
   end

   // ==========================================================
   // Next state
   always_comb begin
      s_d = s_q;
      s_d.rvalid = 1'b0;
      s_d.pin_last = src_lvl;
      s_d.bypass = ~enabled & legacy_irq;

      // Timer counts down from its initial count; one-shot at zero
      if (s_q.timer_cur != 32'h00000000) begin
         s_d.timer_cur = s_q.timer_cur - 32'h00000001;
      end

      // core_ack clears the core delivery, whatever its delivery mode
      if (core_ack && s_q.core_out.valid && s_q.core_out.mode != lic_pkg::LIC_DM_FIXED) begin
         s_d.core_out.valid = 1'b0;
      end
      if (core_ack && s_q.core_out.valid) begin
         s_d.core_out.valid = 1'b0;
      end

      // Register access
      if (reg_req.wr || reg_req.rd) begin
         if (!hit_ok) begin
            s_d.err_status[`LIC_ERR_ILLEGAL_REG_BIT] = 1'b1;
            // Only raised when software has unmasked the error entry
            if (!s_q.entry[`LIC_SRC_ERROR][`LIC_ENT_MASK_BIT]) begin
               s_d.pend[`LIC_SRC_ERROR] = 1'b1;
            end
         end
         s_d.rvalid = reg_req.rd;
         case (idx)
            `LIC_IDX_ERR_STATUS: s_d.rdata = {24'h000000, s_q.err_status};
            `LIC_IDX_CMD_LO: s_d.rdata = s_q.cmd_lo;
            `LIC_IDX_CMD_HI: s_d.rdata = s_q.cmd_hi;
            `LIC_IDX_TIMER: s_d.rdata = s_q.entry[`LIC_SRC_TIMER];
            `LIC_IDX_THERM: s_d.rdata = s_q.entry[`LIC_SRC_THERM];
            `LIC_IDX_PERF: s_d.rdata = s_q.entry[`LIC_SRC_PERF];
            `LIC_IDX_PIN_A: s_d.rdata = s_q.entry[`LIC_SRC_PIN_A];
            `LIC_IDX_PIN_B: s_d.rdata = s_q.entry[`LIC_SRC_PIN_B];
            `LIC_IDX_ERROR: s_d.rdata = s_q.entry[`LIC_SRC_ERROR];
            `LIC_IDX_TIMER_INIT: s_d.rdata = s_q.timer_init;
            `LIC_IDX_TIMER_CUR: s_d.rdata = s_q.timer_cur;
            `LIC_IDX_SPURIOUS: s_d.rdata = {23'h000000, s_q.spurious};
            default: s_d.rdata = 32'h00000000;
         endcase
         // A refused read must not leak a neighbouring register's contents
         if (!hit_ok) begin
            s_d.rdata = 32'h00000000;
         end
         if (reg_req.wr && hit_ok) begin
            case (idx)
               `LIC_IDX_ERR_STATUS: s_d.err_status = 8'h00;
               `LIC_IDX_CMD_HI: s_d.cmd_hi = reg_req.wdata;
               `LIC_IDX_CMD_LO: begin
                  s_d.cmd_lo = reg_req.wdata;
                  if (s_q.cmd_state == lic_pkg::LIC_ST_IDLE) begin
                     s_d.cmd_state = lic_pkg::LIC_ST_SEND;
                  end
               end
               `LIC_IDX_TIMER: s_d.entry[`LIC_SRC_TIMER] = reg_req.wdata;
               `LIC_IDX_THERM: s_d.entry[`LIC_SRC_THERM] = reg_req.wdata;
               `LIC_IDX_PERF: s_d.entry[`LIC_SRC_PERF] = reg_req.wdata;
               `LIC_IDX_PIN_A: s_d.entry[`LIC_SRC_PIN_A] = reg_req.wdata;
               `LIC_IDX_PIN_B: s_d.entry[`LIC_SRC_PIN_B] = reg_req.wdata;
               `LIC_IDX_ERROR: s_d.entry[`LIC_SRC_ERROR] = reg_req.wdata;
               `LIC_IDX_TIMER_INIT: begin
                  s_d.timer_init = reg_req.wdata;
                  s_d.timer_cur = reg_req.wdata;
               end
               `LIC_IDX_SPURIOUS: s_d.spurious = reg_req.wdata[8:0];
               default: s_d.spurious = s_q.spurious;
            endcase
         end
      end

      // Latch source events unless masked; the delivery clear below repeats the set so it can win
      for (int i = 0; i < `LIC_NUM_SRC; i++) begin
         if (src_evt[i] && !s_q.entry[i][`LIC_ENT_MASK_BIT] && enabled) begin
            s_d.pend[i] = 1'b1;
         end
      end
      if (timer_hit) begin
         s_d.pend[`LIC_SRC_TIMER] = 1'b1;
      end

      // Outgoing message machine; partner handshakes with link_ready
      case (s_q.cmd_state)
         lic_pkg::LIC_ST_IDLE: s_d.link_out.valid = 1'b0;
         lic_pkg::LIC_ST_SEND: begin
            s_d.link_out.valid = 1'b1;
            s_d.link_out.vector = s_q.cmd_lo[7:0];
            s_d.link_out.mode = lic_pkg::lic_mode_t'(s_q.cmd_lo[10:8]);
            s_d.link_out.level = s_q.cmd_lo[`LIC_CMD_LEVEL_BIT];
            s_d.link_out.shorthand = lic_pkg::lic_short_t'(s_q.cmd_lo[19:18]);
            s_d.link_out.dest = s_q.cmd_hi[31:24];
            s_d.cmd_state = lic_pkg::LIC_ST_WAIT;
         end
         lic_pkg::LIC_ST_WAIT: begin
            if (link_ready) begin
               s_d.link_out.valid = 1'b0;
               s_d.cmd_state = lic_pkg::LIC_ST_IDLE;
            end
         end
         default: s_d.cmd_state = lic_pkg::LIC_ST_IDLE;
      endcase

      // Core delivery: incoming messages first, then local sources
      if (!s_q.core_out.valid || core_ack) begin
         if (enabled && link_in.valid) begin
            s_d.core_out = link_in;
         end else if (enabled && s_q.cmd_state == lic_pkg::LIC_ST_WAIT && link_ready &&
                      s_q.link_out.shorthand inside {lic_pkg::LIC_SH_SELF, lic_pkg::LIC_SH_ALL}) begin
            s_d.core_out = s_q.link_out; // self copy
         end else if (pick_ok) begin
            // Clear on delivery, but a fresh event of the same source wins
            s_d.pend[pick] = src_evt[pick] & ~s_q.entry[pick][`LIC_ENT_MASK_BIT] & enabled;
            if (pick == `LIC_SRC_TIMER && timer_hit) begin
               s_d.pend[pick] = 1'b1;
            end
            if (pick == `LIC_SRC_ERROR && err_hit &&
                !s_q.entry[pick][`LIC_ENT_MASK_BIT]) begin
               s_d.pend[pick] = 1'b1;
            end
            s_d.core_out.valid = 1'b1;
            s_d.core_out.vector = s_q.entry[pick][7:0];
            s_d.core_out.mode = lic_pkg::lic_mode_t'(s_q.entry[pick][10:8]);
            s_d.core_out.level = s_q.entry[pick][`LIC_ENT_LEVEL_BIT];
            s_d.core_out.shorthand = lic_pkg::LIC_SH_SELF;
            s_d.core_out.dest = 8'h00;
            if (pick == `LIC_SRC_PIN_B && s_q.entry[pick][10:8] == lic_pkg::LIC_DM_NMI) begin
               s_d.core_out.vector = `LIC_NMI_VECTOR;
            end
         end
      end
   end

   // ==========================================================
   // State register; clk_en freezes everything
   // Reset leaves every entry masked and the controller disabled, so no
   // source can fire before software has set the table up
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         s_q <= '0;
         for (int i = 0; i < `LIC_NUM_SRC; i++) begin
            s_q.entry[i] <= `LIC_ENT_RESET;
         end
      end else if (clk_en) begin
         s_q <= s_d;
      end
   end

   // Every output is a plain copy of a state flip-flop
   assign reg_rdata = s_q.rdata;
   assign reg_rvalid = s_q.rvalid;
   assign link_out = s_q.link_out;
   assign core_irq = s_q.core_out;
   assign core_legacy_irq = s_q.bypass;
endmodule
`default_nettype wire

/* File: testbench/lic_properties.sv */
/* Port-level checker for the local interrupt controller.
 Assumes the bind below and clk_en held high around commands. */
`timescale 1ns/1ps
`default_nettype none
`include "lic_regs.svh"
module lic_properties (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire lic_pkg::lic_req_t reg_req,
   input wire logic [31:0] reg_rdata,
   input wire logic reg_rvalid,
   input wire logic legacy_irq,
   input wire lic_pkg::lic_msg_t link_in,
   input wire logic link_ready,
   input wire lic_pkg::lic_msg_t link_out,
   input wire lic_pkg::lic_msg_t core_irq,
   input wire logic core_ack,
   input wire logic core_legacy_irq
);
   // ==========================================================
   // Clocking and command sequences
   // Reset quiets every check, so no property sees the reset cycles
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);
   // Idle link first, else a write during a transfer is stored but legally not sent
   sequence s_link_idle;
      !link_out.valid [*3];
   endsequence
   sequence s_cmd_wr;
      clk_en && reg_req.wr && reg_req.addr == {`LIC_IDX_CMD_LO, 4'h0};
   endsequence
   // ==========================================================
   // Properties
   a_read_answer: assert property (reg_req.rd && clk_en |=> reg_rvalid)
      else $error("read not answered");
   a_answer_cause: assert property (reg_rvalid |-> $past(reg_req.rd))
      else $error("answer without read");
   a_bad_read: assert property (reg_req.rd && clk_en && reg_req.addr[3:0] != 4'h0
      |=> reg_rdata == 32'h0) else $error("misaligned read not zero");
   a_link_hold: assert property (link_out.valid && !link_ready |=> $stable(link_out))
      else $error("link message changed before ready");
   a_link_done: assert property (link_out.valid && link_ready && clk_en |=> !link_out.valid)
      else $error("link message kept after ready");
   a_core_hold: assert property (core_irq.valid && !core_ack |=> $stable(core_irq))
      else $error("core delivery changed before ack");
   a_cmd_launch: assert property (s_link_idle ##0 s_cmd_wr |-> ##[1:4] link_out.valid)
      else $error("command write sent nothing");
   a_rx_deliver: assert property (link_in.valid && !core_irq.valid && clk_en
      |-> ##[1:3] core_irq.valid) else $error("incoming message not delivered");
   a_legacy_path: assert property ($rose(core_legacy_irq) |-> $past(legacy_irq))
      else $error("legacy output without legacy request");
endmodule
bind lic_local_interrupt_controller lic_properties lic_properties_i (.sys_clk, .sys_rst, .clk_en,
   .reg_req, .reg_rdata, .reg_rvalid, .legacy_irq, .link_in, .link_ready, .link_out, .core_irq,
   .core_ack, .core_legacy_irq);
`default_nettype wire

/* File: testbench/lic_link_partner.sv */
/* Link partner model: accepts outgoing messages after a set stall and
 injects incoming messages on request. Assumes link_out holds until ready. */
`timescale 1ns/1ps
`default_nettype none
module lic_link_partner (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire lic_pkg::lic_msg_t link_out,
   output logic link_ready,
   output lic_pkg::lic_msg_t link_in,
   input wire logic [3:0] stall,
   input wire logic send,
   input wire lic_pkg::lic_msg_t send_msg,
   output lic_pkg::lic_msg_t rx_msg,
   output logic [7:0] rx_cnt
);
   logic [3:0] wait_q;
   // ==========================================================
   // Accept side: ready after stall cycles, one cycle wide
   always_ff @(posedge sys_clk) begin
      link_ready <= 1'b0;
      if (sys_rst) begin
         wait_q <= 4'h0;
         rx_cnt <= 8'h00;
      end else if (link_out.valid && !link_ready) begin
         if (wait_q == stall) begin
            link_ready <= 1'b1;
            rx_msg <= link_out;
            rx_cnt <= rx_cnt + 8'h01;
            wait_q <= 4'h0;
         end else begin
            wait_q <= wait_q + 4'h1;
         end
      end
   end
   // Send side: idle fields toggle so stale data can never pass as a message
   always_ff @(posedge sys_clk) begin
      if (sys_rst) link_in <= '0;
      else if (send) link_in <= send_msg;
      else link_in <= {1'b0, ~link_in[21:0]};
   end
endmodule
`default_nettype wire

/* File: testbench/tb.sv */
/* Self-checking bench for the local interrupt controller.
 Assumes the link partner model and the bound port checker. */
`timescale 1ns/1ps
`default_nettype none
`include "lic_regs.svh"
module tb;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic clk_en = 1'b1;
   logic local_irq_pin_a = 1'b0;
   logic local_irq_pin_b = 1'b0;
   logic perf_overflow = 1'b0;
   logic thermal_trip = 1'b0;
   logic legacy_irq = 1'b0;
   logic core_ack = 1'b0;
   logic send = 1'b0;
   logic link_ready, reg_rvalid, core_legacy_irq;
   logic [3:0] stall = 4'h0;
   logic [7:0] rx_cnt;
   logic [31:0] reg_rdata, d;
   lic_pkg::lic_req_t reg_req = '0;
   lic_pkg::lic_msg_t link_in, link_out, core_irq, rx_msg;
   lic_pkg::lic_msg_t send_msg = '0;
   int failures = 0;
   int checked = 0;
   // ==========================================================
   // Design, partner and clock
   lic_local_interrupt_controller lic_local_interrupt_controller_i (.sys_clk, .sys_rst,
      .clk_en, .reg_req, .reg_rdata, .reg_rvalid, .local_irq_pin_a, .local_irq_pin_b,
      .perf_overflow, .thermal_trip, .legacy_irq, .link_in, .link_ready, .link_out, .core_irq,
      .core_ack, .core_legacy_irq);
   lic_link_partner lic_link_partner_i (.sys_clk, .sys_rst, .link_out, .link_ready, .link_in,
      .stall, .send, .send_msg, .rx_msg, .rx_cnt);
   always #5 sys_clk = ~sys_clk;
   // ==========================================================
   // Shared tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic summarize;
      $display("checks %0d, mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // One settled cycle; a used-up bound ends the run
   task automatic step(inout int n);
      @(posedge sys_clk) #1;
      n++;
      if (n == 40) begin
         failures++;
         summarize();
      end
   endtask
   task automatic wr(input logic [7:0] idx, input logic [31:0] v);
      @(posedge sys_clk) reg_req <= {2'b10, idx, 4'h0, v};
      @(posedge sys_clk) reg_req <= '0;
   endtask
   task automatic rd(input logic [11:0] a);
      @(posedge sys_clk) reg_req <= {2'b01, a, 32'h0};
      @(posedge sys_clk) reg_req <= '0;
      #1 chk({31'h0, reg_rvalid}, 32'h1);
      d = reg_rdata;
   endtask
   // Wait for a delivery, compare it, then acknowledge it
   task automatic take(input logic [7:0] v, input logic [2:0] m, input logic l);
      int n;
      n = 0;
      while (core_irq.valid !== 1'b1) step(n);
      chk({20'h0, core_irq.level, core_irq.mode, core_irq.vector}, {20'h0, l, m, v});
      @(posedge sys_clk) core_ack <= 1'b1;
      @(posedge sys_clk) core_ack <= 1'b0;
      #1;
   endtask
   // Table entry: unmasked, given vector, mode and trigger
   function automatic logic [31:0] ent(input logic [7:0] v, input logic [2:0] m, input logic l);
      return {16'h0, l, 4'h0, m, v};
   endfunction
   // ==========================================================
   // Scenarios
   task automatic t_reset;
      for (int i = 0; i < 6; i++) begin
         rd({8'(`LIC_IDX_TIMER + i), 4'h0});
         chk(d, `LIC_ENT_RESET);
      end
      rd({`LIC_IDX_SPURIOUS, 4'h0});
      chk({31'h0, d[8]}, 32'h0);
      @(posedge sys_clk) legacy_irq <= 1'b1;
      repeat (2) @(posedge sys_clk);
      #1 chk({31'h0, core_legacy_irq}, 32'h1);
      wr(`LIC_IDX_SPURIOUS, 32'h00000100);
      repeat (2) @(posedge sys_clk);
      #1 chk({31'h0, core_legacy_irq}, 32'h0);
      legacy_irq <= 1'b0;
      $display("reset and bypass test done");
   endtask
   // Pin B and the event inputs; each pulse is an edge request
   task automatic t_local;
      wr(`LIC_IDX_PIN_B, ent(8'h55, 3'h4, 1'b0));
      @(posedge sys_clk) local_irq_pin_b <= 1'b1;
      repeat (2) @(posedge sys_clk);
      local_irq_pin_b <= 1'b0;
      take(`LIC_NMI_VECTOR, 3'h4, 1'b0);
      // Pin A, perf and thermal sit at 0x35, 0x34, 0x33 in bit order
      for (int i = 0; i < 3; i++) begin
         wr(8'(`LIC_IDX_PIN_A - i), ent(8'(8'h40 + i), 3'h0, 1'b0));
         @(posedge sys_clk) {thermal_trip, perf_overflow, local_irq_pin_a} <= 3'b001 << i;
         repeat (2) @(posedge sys_clk);
         {thermal_trip, perf_overflow, local_irq_pin_a} <= 3'h0;
         take(8'(8'h40 + i), 3'h0, 1'b0);
      end
      wr(`LIC_IDX_TIMER, ent(8'h60, 3'h0, 1'b0));
      wr(`LIC_IDX_TIMER_INIT, 32'h00000005);
      take(8'h60, 3'h0, 1'b0);
      wr(`LIC_IDX_ERROR, ent(8'h70, 3'h0, 1'b0));
      rd(12'h354);
      chk(d, 32'h0);
      take(8'h70, 3'h0, 1'b0);
      rd({`LIC_IDX_ERR_STATUS, 4'h0});
      chk({31'h0, d[`LIC_ERR_ILLEGAL_REG_BIT]}, 32'h1);
      $display("local source test done");
   endtask
   // Fixed, SMM, NMI, INIT and start modes to others, prompt and slow, then one to self
   task automatic t_send;
      logic [2:0] md [6] = '{3'h0, 3'h2, 3'h4, 3'h5, 3'h6, 3'h0};
      logic [7:0] c;
      int n;
      wr(`LIC_IDX_CMD_HI, 32'h5A000000);
      for (int i = 0; i < 6; i++) begin
         stall <= 4'(i);
         c = rx_cnt;
         n = 0;
         wr(`LIC_IDX_CMD_LO, {12'h0, (i == 5) ? 2'h1 : 2'h3, 7'h0, md[i], 8'(8'h20 + i)});
         while (rx_cnt === c) step(n);
         chk({rx_msg.dest, 6'h0, rx_msg.shorthand, 5'h0, rx_msg.mode, rx_msg.vector},
            {8'h5A, 6'h0, (i == 5) ? 2'h1 : 2'h3, 5'h0, md[i], 8'(8'h20 + i)});
         repeat (4) @(posedge sys_clk);
      end
      take(8'h25, 3'h0, 1'b0);
      $display("message send test done");
   endtask
   task automatic t_receive;
      @(posedge sys_clk) send_msg <= {1'b1, 8'h77, 3'h0, 1'b1, 2'h0, 8'h00};
      send <= 1'b1;
      @(posedge sys_clk) send <= 1'b0;
      take(8'h77, 3'h0, 1'b1);
      $display("message receive test done");
   endtask
   // ==========================================================
   // Main sequence
   initial begin
      repeat (5) @(posedge sys_clk);
      sys_rst <= 1'b0;
      t_reset();
      t_local();
      t_send();
      t_receive();
      summarize();
   end
endmodule
`default_nettype wire
